// >>> inc/port_defs.vh
// register map, field positions and reset values of the bidirectional port block
// Contract
// - eight pins, each with its own data latch, direction bit and pullup-enable bit, all read/write
// - reset leaves the data latches unchanged
// - direction bit 1 drives the pin, 0 makes it an input
// - reset clears all eight direction bits, pins come up as inputs
// - output pin reads back its latch value
// - input pin reads back the level on the pin
// - data latch always writable whatever the direction
// - writing an input pin's data only changes the latch, not the read value
// - pullup on only when pullup-enable is 1 and direction is 0
// - pullup drops at once whenever direction selects output
// - pullup-enable 0 keeps pullup off, input floats
// - input-only pin of six-bit port never drives
// - writing six-bit port input data only changes the latch; the code reads input-only pin 2 from its latch while its direction bit is 1
// - six-bit port has six latches, direction and pullup bits alike
// - with external interrupt on, bit 2 of six-bit data reads 0
`ifndef PORT_DEFS_VH
`define PORT_DEFS_VH
`define ADDR_W           4
`define OFF_B_DATA       4'h0
`define OFF_B_DIR        4'h1
`define OFF_B_PULLUP     4'h2
`define OFF_A_DATA       4'h3
`define OFF_A_DIR        4'h4
`define OFF_A_PULLUP     4'h5
`define OFF_A_CTRL       4'h6
`define CTRL_IRQ_EN_BIT  0
`define INPUT_ONLY_BIT   2
`define DIR_RESET        8'h00
`define PULLUP_RESET     8'h00
`define CTRL_RESET       1'b0
`endif

// >>> rtl/pin_slice.v
// one general-purpose pin: data latch, direction, pullup, synchroniser and read mux
`default_nettype none
module pin_slice #(
  parameter INPUT_ONLY = 0
) (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire wr_data,
  input  wire wr_dir,
  input  wire wr_pull,
  input  wire wdata,
  input  wire pin_in,
  output wire pin_out,
  output wire pin_oe,
  output wire pullup_en,
  output wire rd_data,
  output wire dir,
  output wire pull
);
  reg latch_q;
  reg dir_q;
  reg pull_q;
  reg sync1_q;
  reg sync2_q;

  // latch has no reset so its contents survive reset
  always @(posedge clk) begin
    if (ce && wr_data) begin
      latch_q <= wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q   <= 1'b0;
      pull_q  <= 1'b0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce) begin
      if (wr_dir) begin
        dir_q <= wdata;
      end
      if (wr_pull) begin
        pull_q <= wdata;
      end
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign pin_out   = latch_q;
  assign pin_oe    = (INPUT_ONLY != 0) ? 1'b0 : dir_q;
  assign pullup_en = pull_q & ~dir_q;
  assign rd_data   = dir_q ? latch_q : sync2_q;
  assign dir       = dir_q;
  assign pull      = pull_q;
endmodule // pin_slice
`default_nettype wire

// >>> rtl/gpio_ports.v
// two general-purpose ports (eight and six pins) behind an avalon-mm slave
`include "port_defs.vh"
`default_nettype none
module gpio_ports #(
  parameter B_W = 8,
  parameter A_W = 6
) (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 ce,
  input  wire [`ADDR_W-1:0]   address,
  input  wire                 read,
  input  wire                 write,
  input  wire [31:0]          writedata,
  input  wire [3:0]           byteenable,
  output reg  [31:0]          readdata,
  output wire                 waitrequest,
  input  wire [B_W-1:0]       b_pin_in,
  output wire [B_W-1:0]       b_pin_out,
  output wire [B_W-1:0]       b_pin_oe,
  output wire [B_W-1:0]       b_pullup_en,
  input  wire [A_W-1:0]       a_pin_in,
  output wire [A_W-1:0]       a_pin_out,
  output wire [A_W-1:0]       a_pin_oe,
  output wire [A_W-1:0]       a_pullup_en
);
  reg         ack_q;
  reg         irq_en_q;
  reg  [31:0] rd_d;
  wire        wr_ok;
  wire [B_W-1:0] b_rd;
  wire [B_W-1:0] b_dir;
  wire [B_W-1:0] b_pull;
  wire [A_W-1:0] a_rd;
  wire [A_W-1:0] a_dir;
  wire [A_W-1:0] a_pull;

  wire        wr_b_data;
  wire        wr_b_dir;
  wire        wr_b_pull;
  wire        wr_a_data;
  wire        wr_a_dir;
  wire        wr_a_pull;

  // one wait cycle: a write lands at the edge where waitrequest is seen low
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_ok = ce & write & ack_q & byteenable[0];

  assign wr_b_data = wr_ok && (address == `OFF_B_DATA);
  assign wr_b_dir  = wr_ok && (address == `OFF_B_DIR);
  assign wr_b_pull = wr_ok && (address == `OFF_B_PULLUP);
  assign wr_a_data = wr_ok && (address == `OFF_A_DATA);
  assign wr_a_dir  = wr_ok && (address == `OFF_A_DIR);
  assign wr_a_pull = wr_ok && (address == `OFF_A_PULLUP);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q    <= 1'b0;
      irq_en_q <= `CTRL_RESET;
      readdata <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= (read | write) & ~ack_q;
      if (read & ~ack_q) begin
        readdata <= rd_d;
      end
      if (wr_ok && address == `OFF_A_CTRL) begin
        irq_en_q <= writedata[`CTRL_IRQ_EN_BIT];
      end
    end
  end

  // eight-bit port, one slice per pin (instances assume the default width)
  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b0 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[0]),
    .pin_in    (b_pin_in[0]),
    .pin_out   (b_pin_out[0]),
    .pin_oe    (b_pin_oe[0]),
    .pullup_en (b_pullup_en[0]),
    .rd_data   (b_rd[0]),
    .dir       (b_dir[0]),
    .pull      (b_pull[0])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b1 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[1]),
    .pin_in    (b_pin_in[1]),
    .pin_out   (b_pin_out[1]),
    .pin_oe    (b_pin_oe[1]),
    .pullup_en (b_pullup_en[1]),
    .rd_data   (b_rd[1]),
    .dir       (b_dir[1]),
    .pull      (b_pull[1])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b2 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[2]),
    .pin_in    (b_pin_in[2]),
    .pin_out   (b_pin_out[2]),
    .pin_oe    (b_pin_oe[2]),
    .pullup_en (b_pullup_en[2]),
    .rd_data   (b_rd[2]),
    .dir       (b_dir[2]),
    .pull      (b_pull[2])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b3 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[3]),
    .pin_in    (b_pin_in[3]),
    .pin_out   (b_pin_out[3]),
    .pin_oe    (b_pin_oe[3]),
    .pullup_en (b_pullup_en[3]),
    .rd_data   (b_rd[3]),
    .dir       (b_dir[3]),
    .pull      (b_pull[3])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b4 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[4]),
    .pin_in    (b_pin_in[4]),
    .pin_out   (b_pin_out[4]),
    .pin_oe    (b_pin_oe[4]),
    .pullup_en (b_pullup_en[4]),
    .rd_data   (b_rd[4]),
    .dir       (b_dir[4]),
    .pull      (b_pull[4])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b5 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[5]),
    .pin_in    (b_pin_in[5]),
    .pin_out   (b_pin_out[5]),
    .pin_oe    (b_pin_oe[5]),
    .pullup_en (b_pullup_en[5]),
    .rd_data   (b_rd[5]),
    .dir       (b_dir[5]),
    .pull      (b_pull[5])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b6 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[6]),
    .pin_in    (b_pin_in[6]),
    .pin_out   (b_pin_out[6]),
    .pin_oe    (b_pin_oe[6]),
    .pullup_en (b_pullup_en[6]),
    .rd_data   (b_rd[6]),
    .dir       (b_dir[6]),
    .pull      (b_pull[6])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_b7 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_pull   (wr_b_pull),
    .wdata     (writedata[7]),
    .pin_in    (b_pin_in[7]),
    .pin_out   (b_pin_out[7]),
    .pin_oe    (b_pin_oe[7]),
    .pullup_en (b_pullup_en[7]),
    .rd_data   (b_rd[7]),
    .dir       (b_dir[7]),
    .pull      (b_pull[7])
  );

  // six-bit port; pin 2 is input only and never drives
  pin_slice #(
    .INPUT_ONLY (0)
  ) u_a0 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[0]),
    .pin_in    (a_pin_in[0]),
    .pin_out   (a_pin_out[0]),
    .pin_oe    (a_pin_oe[0]),
    .pullup_en (a_pullup_en[0]),
    .rd_data   (a_rd[0]),
    .dir       (a_dir[0]),
    .pull      (a_pull[0])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_a1 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[1]),
    .pin_in    (a_pin_in[1]),
    .pin_out   (a_pin_out[1]),
    .pin_oe    (a_pin_oe[1]),
    .pullup_en (a_pullup_en[1]),
    .rd_data   (a_rd[1]),
    .dir       (a_dir[1]),
    .pull      (a_pull[1])
  );

  pin_slice #(
    .INPUT_ONLY (1)
  ) u_a2 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[2]),
    .pin_in    (a_pin_in[2]),
    .pin_out   (a_pin_out[2]),
    .pin_oe    (a_pin_oe[2]),
    .pullup_en (a_pullup_en[2]),
    .rd_data   (a_rd[2]),
    .dir       (a_dir[2]),
    .pull      (a_pull[2])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_a3 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[3]),
    .pin_in    (a_pin_in[3]),
    .pin_out   (a_pin_out[3]),
    .pin_oe    (a_pin_oe[3]),
    .pullup_en (a_pullup_en[3]),
    .rd_data   (a_rd[3]),
    .dir       (a_dir[3]),
    .pull      (a_pull[3])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_a4 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[4]),
    .pin_in    (a_pin_in[4]),
    .pin_out   (a_pin_out[4]),
    .pin_oe    (a_pin_oe[4]),
    .pullup_en (a_pullup_en[4]),
    .rd_data   (a_rd[4]),
    .dir       (a_dir[4]),
    .pull      (a_pull[4])
  );

  pin_slice #(
    .INPUT_ONLY (0)
  ) u_a5 (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_pull   (wr_a_pull),
    .wdata     (writedata[5]),
    .pin_in    (a_pin_in[5]),
    .pin_out   (a_pin_out[5]),
    .pin_oe    (a_pin_oe[5]),
    .pullup_en (a_pullup_en[5]),
    .rd_data   (a_rd[5]),
    .dir       (a_dir[5]),
    .pull      (a_pull[5])
  );

  always @* begin
    rd_d = 32'h0000_0000;
    case (address)
      `OFF_B_DATA:   rd_d[B_W-1:0] = b_rd;
      `OFF_B_DIR:    rd_d[B_W-1:0] = b_dir;
      `OFF_B_PULLUP: rd_d[B_W-1:0] = b_pull;
      `OFF_A_DATA: begin
        rd_d[A_W-1:0] = a_rd;
        if (irq_en_q) begin
          rd_d[`INPUT_ONLY_BIT] = 1'b0;
        end
      end
      `OFF_A_DIR:    rd_d[A_W-1:0] = a_dir;
      `OFF_A_PULLUP: rd_d[A_W-1:0] = a_pull;
      `OFF_A_CTRL:   rd_d[0] = irq_en_q;
      default:       rd_d = 32'h0000_0000;
    endcase
  end
endmodule // gpio_ports
`default_nettype wire

// >>> bench/gpio_ports_checker.sv
// bus and pin assertions for the gpio port block
`default_nettype none
module gpio_chk #(parameter B_W = 8, parameter A_W = 6) (
  input wire logic           clk,
  input wire logic           rst,
  input wire logic [3:0]     address,
  input wire logic           read,
  input wire logic           write,
  input wire logic [31:0]    writedata,
  input wire logic           waitrequest,
  input wire logic [B_W-1:0] b_pin_out,
  input wire logic [B_W-1:0] b_pin_oe,
  input wire logic [B_W-1:0] b_pullup_en
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       w = write & ~waitrequest;
  wire [7:0] d = writedata[7:0];
  a_dir_load: assert property (w && address == 4'h1 |=> b_pin_oe == $past(d)) else $error("dir");
  a_data_load: assert property (w && !address |=> b_pin_out == $past(d)) else $error("data");
  a_pull_load: assert property (w && address == 4'h2 |=> b_pullup_en == ($past(d) & ~b_pin_oe))
    else $error("pullup");
  a_pull_off: assert property (!(b_pullup_en & b_pin_oe)) else $error("pull");
  a_dir_reset: assert property ($fell(rst) |-> !b_pin_oe) else $error("reset");
  a_dir_hold: assert property (!(write && address == 4'h1) |=> $stable(b_pin_oe))
    else $error("dir moved");
  a_wait_first: assert property ($rose(read) |-> waitrequest) else $error("wait");
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  cover property (w && address == 4'h1);
  cover property ($rose(read) && address == 4'h3);
  cover property ($fell(rst));
endmodule // gpio_chk
bind gpio_ports gpio_chk #(.B_W(B_W), .A_W(A_W)) i_chk (.clk, .rst, .address, .read, .write,
  .writedata, .waitrequest, .b_pin_out, .b_pin_oe, .b_pullup_en);
`default_nettype wire

// >>> bench/pad_model.sv
// pad model: device drive wins, then external drive, then pullup, else the pad wanders
`default_nettype none
module pad_model #(parameter W = 8) (
  input  wire logic         clk,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] xe,
  input  wire logic [W-1:0] xv,
  output wire logic [W-1:0] pad
);
  timeunit 1ns / 1ns;
  logic [W-1:0] fl = '0;
  always @(posedge clk) fl <= ~fl;
  assign pad = oe & out | ~oe & (xe & xv | ~xe & (pu | fl));
endmodule // pad_model
`default_nettype wire

// >>> bench/bidirectional_port_with_pullups_tb_top.sv
// self-checking bench for the gpio port block
`default_nettype none
module bidirectional_port_with_pullups_tb_top;
  timeunit 1ns / 1ns;
  logic        clk = 0, rst = 1, read = 0, write = 0, waitrequest;
  logic [3:0]  address = 0;
  logic [31:0] writedata = 0, readdata;
  logic [7:0]  bi, bo, boe, bpu, bxe = 8'h0f, bxv = 8'h0a;
  logic [5:0]  ai, ao, aoe, apu, axe = 6'h3f, axv = 6'h15;
  int          num_errors = 0, checks_done = 0;
  // each row: write address, write data, read address, expected read
  logic [23:0] rows [11] = '{24'h15a15a, 24'h2ff2ff, 24'h7ff700, 24'h00f0aa, 24'h200200,
    24'h03c15a, 24'h1ff03c, 24'h32e315, 24'h601311, 24'h4ff32a, 24'h5ff43f};
  gpio_ports i_dut (.clk, .rst, .ce(1'b1), .address, .read, .write, .writedata,
    .byteenable(4'h1), .readdata, .waitrequest, .b_pin_in(bi), .b_pin_out(bo), .b_pin_oe(boe),
    .b_pullup_en(bpu), .a_pin_in(ai), .a_pin_out(ao), .a_pin_oe(aoe), .a_pullup_en(apu));
  pad_model pb (.clk, .out(bo), .oe(boe), .pu(bpu), .xe(bxe), .xv(bxv), .pad(bi));
  pad_model #(.W(6)) pa (.clk, .out(ao), .oe(aoe), .pu(apu), .xe(axe), .xv(axv), .pad(ai));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, e);
    @(posedge clk);
    {write, read, address, writedata} <= {w, !w, a, 24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    if (!w) chk(readdata[7:0], e);
    {write, read} <= 2'b00;
  endtask
  task stop_test;
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(1'b0, 4'h1, 8'h0, 8'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][23:20], rows[i][19:12], 8'h0);
      bus(1'b0, rows[i][11:8], 8'h0, rows[i][7:0]);
    end
    chk({2'b0, aoe}, 8'h3b);
    chk({2'b0, ao}, 8'h2e);
    chk({2'b0, apu}, 8'h00);
    chk(bpu, 8'h00);
    chk(boe, 8'hff);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    chk(bo, 8'h3c);
    bus(1'b0, 4'h1, 8'h0, 8'h0);
    stop_test();
  end
endmodule // bidirectional_port_with_pullups_tb_top
`default_nettype wire
